// ==== phy_event_status_and_error_counters.sv ====
// Function
// - bit 15 latches an energy-efficient-Ethernet error until read; resets to zero.
// - bit 14 latches an auto-negotiation error event as pending.
// - bit 13 latches when a page arrives from the link partner.
// - bit 12 latches on loopback FIFO overflow or underflow, one shared bit.
// - bit 11 latches whenever the crossover state changes.
// - bit 10 latches on any sleep-mode event.
// - bit 9 latches on receive polarity change or wake packet.
// - bit 8 latches when jabber is detected.
// - bits 7..0 are read-write enables pairing with bits 15..8, reset zero.
// - 8-bit false-carrier counter in bits 7:0 counts events; upper bits zero.
// - false-carrier counter stops at its maximum.
// - false-carrier counter passing half-full raises an event.
// - reading a counter register clears that counter.
// - 16-bit receive-error counter counts invalid symbols with carrier and rx_dv.
// - receive-error counter holds still in MII loopback mode.
// - receive-error counter stops at its maximum.
// - receive-error counter passing 0x7F raises the half-full event.
// - false-carrier half-full event reaches interrupt only when its enable set.
// - receive-error half-full event reaches interrupt only when its enable set.
`include "event_status_map.svh"
`timescale 1ns/100ps
`default_nettype none

module phy_event_status_and_error_counters
#(
   parameter int FC_WIDTH = 8,
   parameter int RE_WIDTH = 16
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire event_status_pkg::wb_req_type wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // phy event sources
   input wire event_status_pkg::phy_event_type events_i,
   input wire event_status_pkg::rx_stat_type rx_i,
   // interrupt
   output logic irq_o
);

   // ==========================================================
   // address decode
   // ==========================================================

   function automatic logic hit(input logic [31:0] adr,
                                input logic [7:0] idx);
      hit = (adr[31:10] == 22'h0) && (adr[9:2] == idx);
   endfunction

   logic req;
   logic rd;
   logic wr;
   logic hit_status;
   logic hit_fc;
   logic hit_re;
   logic hit_hf;

   assign req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   assign rd = req && !wb_req_i.we;
   assign wr = req && wb_req_i.we;
   assign hit_status = hit(wb_req_i.adr, `IDX_INT_STATUS_ENABLE_2);
   assign hit_fc = hit(wb_req_i.adr, `IDX_FALSE_CARRIER_COUNT);
   assign hit_re = hit(wb_req_i.adr, `IDX_RECEIVE_ERROR_COUNT);
   assign hit_hf = hit(wb_req_i.adr, `IDX_HALF_FULL_CONTROL);

   // ==========================================================
   // event conditioning
   // ==========================================================

   logic mdix_prev_q;
   logic polarity_prev_q;
   logic prev_valid_q;
   logic mdix_change;
   logic polarity_change;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mdix_prev_q <= 1'b0;
         polarity_prev_q <= 1'b0;
      end
      else
      begin
         mdix_prev_q <= events_i.mdix_state;
         polarity_prev_q <= events_i.rx_polarity;
      end
   end

   // no change is reported before a first sample exists
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         prev_valid_q <= 1'b0;
      else
         prev_valid_q <= 1'b1;
   end

   assign mdix_change = prev_valid_q &&
                        (mdix_prev_q != events_i.mdix_state);
   assign polarity_change = prev_valid_q &&
                            (polarity_prev_q != events_i.rx_polarity);

   logic [7:0] cond;

   always_comb
   begin
      cond[7] = events_i.eee_error;
      cond[6] = events_i.an_error;
      cond[5] = events_i.page_received;
      cond[4] = events_i.lb_fifo_overflow |
                events_i.lb_fifo_underflow;
      cond[3] = mdix_change;
      cond[2] = events_i.sleep_event;
      cond[1] = polarity_change | events_i.wake_packet;
      cond[0] = events_i.jabber;
   end

   // ==========================================================
   // latched status
   // ==========================================================

   logic [7:0] status;
   logic status_clear;

   assign status_clear = rd && hit_status;

   latched_event_bits
   #(
      .N(8)
   )
   u_status
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cond_i(cond),
      .clear_i(status_clear),
      .status_o(status)
   );

   // ==========================================================
   // enables
   // ==========================================================

   logic [7:0] enable_q;
   logic [1:0] hf_enable_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         enable_q <= `RESET_ENABLES;
      else if (wr && hit_status && wb_req_i.sel[0])
         enable_q <= wb_req_i.dat[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         hf_enable_q <= `RESET_HF_ENABLES;
      else if (wr && hit_hf && wb_req_i.sel[0])
      begin
         hf_enable_q[1] <= wb_req_i.dat[`HF_EN_FALSE_CARRIER_BIT];
         hf_enable_q[0] <= wb_req_i.dat[`HF_EN_RECEIVE_ERROR_BIT];
      end
   end

   // ==========================================================
   // counters
   // ==========================================================

   logic [FC_WIDTH-1:0] fc_count;
   logic [RE_WIDTH-1:0] re_count;
   logic fc_half;
   logic re_half;
   logic fc_clear;
   logic re_clear;
   logic re_inc;

   assign fc_clear = rd && hit_fc;
   assign re_clear = rd && hit_re;
   assign re_inc = rx_i.carrier_valid && rx_i.rx_dv &&
                   rx_i.symbol_error &&
                   !rx_i.mii_loopback;

   sat_event_counter
   #(
      .WIDTH(FC_WIDTH),
      .HALF(FC_WIDTH'(`HALF_FULL_FALSE_CARRIER))
   )
   u_fc_count
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .inc_i(rx_i.false_carrier),
      .clear_i(fc_clear),
      .count_o(fc_count),
      .half_full_o(fc_half)
   );

   sat_event_counter
   #(
      .WIDTH(RE_WIDTH),
      .HALF(RE_WIDTH'(`HALF_FULL_RECEIVE_ERROR))
   )
   u_re_count
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .inc_i(re_inc),
      .clear_i(re_clear),
      .count_o(re_count),
      .half_full_o(re_half)
   );

   // ==========================================================
   // half-full latches
   // ==========================================================

   logic [1:0] hf_status_q;
   logic hf_clear;

   assign hf_clear = rd && hit_hf;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         hf_status_q <= 2'h0;
      else
      begin
         hf_status_q[1] <= fc_half | (hf_status_q[1] & ~hf_clear);
         hf_status_q[0] <= re_half | (hf_status_q[0] & ~hf_clear);
      end
   end

   // ==========================================================
   // interrupt
   // ==========================================================

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= (|(status & enable_q)) |
                  (hf_status_q[1] & hf_enable_q[1]) |
                  (hf_status_q[0] & hf_enable_q[0]);
   end

   // ==========================================================
   // read mux and acknowledge
   // ==========================================================

   logic [31:0] rdata;

   always_comb
   begin
      rdata = 32'h0000_0000;
      if (hit_status)
      begin
         rdata[`STATUS_LSB +: 8] = status;
         rdata[`ENABLE_LSB +: 8] = enable_q;
      end
      else if (hit_fc)
         rdata[FC_WIDTH-1:0] = fc_count;
      else if (hit_re)
         rdata[RE_WIDTH-1:0] = re_count;
      else if (hit_hf)
      begin
         rdata[`HF_STAT_FALSE_CARRIER_BIT] = hf_status_q[1];
         rdata[`HF_STAT_RECEIVE_ERROR_BIT] = hf_status_q[0];
         rdata[`HF_EN_FALSE_CARRIER_BIT] = hf_enable_q[1];
         rdata[`HF_EN_RECEIVE_ERROR_BIT] = hf_enable_q[0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req;
   end

   // unmapped addresses answer with zero data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (rd)
         wb_dat_o <= rdata;
   end

endmodule

`default_nettype wire

// ==== event_status_map.svh ====
`ifndef EVENT_STATUS_MAP_SVH
`define EVENT_STATUS_MAP_SVH

// register indices; the byte address is four times the index
`define IDX_INT_STATUS_ENABLE_2 8'h13
`define IDX_FALSE_CARRIER_COUNT 8'h14
`define IDX_RECEIVE_ERROR_COUNT 8'h15
`define IDX_HALF_FULL_CONTROL 8'h18

// field positions
`define STATUS_LSB 8
`define ENABLE_LSB 0
`define HF_EN_FALSE_CARRIER_BIT 1
`define HF_EN_RECEIVE_ERROR_BIT 0
`define HF_STAT_FALSE_CARRIER_BIT 9
`define HF_STAT_RECEIVE_ERROR_BIT 8

// reset values
`define RESET_ENABLES 8'h00
`define RESET_HF_ENABLES 2'h0
`define RESET_COUNT 16'h0000

// half-full thresholds
`define HALF_FULL_FALSE_CARRIER 8'h7F
`define HALF_FULL_RECEIVE_ERROR 16'h007F

`endif

// ==== event_status_pkg.sv ====
package event_status_pkg;

   typedef struct packed
   {
      logic eee_error;
      logic an_error;
      logic page_received;
      logic lb_fifo_overflow;
      logic lb_fifo_underflow;
      logic mdix_state;
      logic sleep_event;
      logic rx_polarity;
      logic wake_packet;
      logic jabber;
   } phy_event_type;

   typedef struct packed
   {
      logic false_carrier;
      logic rx_dv;
      logic carrier_valid;
      logic symbol_error;
      logic mii_loopback;
   } rx_stat_type;

   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [31:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;

endpackage

// ==== sat_event_counter.sv ====
`timescale 1ns/100ps
`default_nettype none

module sat_event_counter
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] HALF = '1 >> 1
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic inc_i,
   input wire logic clear_i,
   // result
   output logic [WIDTH-1:0] count_o,
   output logic half_full_o
);

   localparam logic [WIDTH-1:0] MAX = '1;

   logic at_max;
   assign at_max = (count_o == MAX);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         count_o <= '0;
      else if (clear_i)
         count_o <= inc_i ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
      else if (inc_i && !at_max)
         count_o <= count_o + 1'b1;
   end

   // one pulse when the count steps past the threshold
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         half_full_o <= 1'b0;
      else
         half_full_o <= inc_i && !clear_i && (count_o == HALF);
   end

endmodule

`default_nettype wire

// ==== latched_event_bits.sv ====
`timescale 1ns/100ps
`default_nettype none

module latched_event_bits
#(
   parameter int N = 8
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // conditions and clear
   input wire logic [N-1:0] cond_i,
   input wire logic clear_i,
   // latched state
   output logic [N-1:0] status_o
);

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         // a condition present during the clear keeps the bit set
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               status_o[i] <= 1'b0;
            else
               status_o[i] <= cond_i[i] | (status_o[i] & ~clear_i);
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ==== phy_event_status_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module phy_event_status_sva
#(
   parameter int FC_WIDTH = 8,
   parameter int RE_WIDTH = 16
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire event_status_pkg::wb_req_type wb_req_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // events and interrupt
   input wire event_status_pkg::phy_event_type events_i,
   input wire event_status_pkg::rx_stat_type rx_i,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic tk, rd, wr, re_hit;
   logic [7:0] cv, st_q, en_q;
   logic [1:0] hen_q, prv_q;
   logic [FC_WIDTH-1:0] fc_q;
   logic [RE_WIDTH-1:0] re_q;
   assign tk = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
   assign rd = tk & ~wb_req_i.we;
   assign wr = tk & wb_req_i.we & wb_req_i.sel[0];
   assign re_hit = &rx_i[3:1] & ~rx_i.mii_loopback;
   assign cv = {events_i.eee_error, events_i.an_error,
      events_i.page_received,
      events_i.lb_fifo_overflow | events_i.lb_fifo_underflow,
      events_i.mdix_state ^ prv_q[1], events_i.sleep_event,
      events_i.wake_packet | (events_i.rx_polarity ^ prv_q[0]),
      events_i.jabber};
   // =====
   // reference model of status, enables and counters
   always_ff @(posedge clk_i)
      prv_q <= {events_i.mdix_state, events_i.rx_polarity};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= 8'h00;
         en_q <= 8'h00;
         hen_q <= 2'h0;
      end
      else
      begin
         st_q <= ((rd && wb_req_i.adr == 32'h4C) ? 8'h00 : st_q) | cv;
         if (wr && wb_req_i.adr == 32'h4C)
            en_q <= wb_req_i.dat[7:0];
         if (wr && wb_req_i.adr == 32'h60)
            hen_q <= wb_req_i.dat[1:0];
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fc_q <= '0;
         re_q <= '0;
      end
      else
      begin
         if (rd && wb_req_i.adr == 32'h50)
            fc_q <= FC_WIDTH'(rx_i.false_carrier);
         else if (rx_i.false_carrier && fc_q != '1)
            fc_q <= fc_q + 1'b1;
         if (rd && wb_req_i.adr == 32'h54)
            re_q <= RE_WIDTH'(re_hit);
         else if (re_hit && re_q != '1)
            re_q <= re_q + 1'b1;
      end
   end
   // =====
   // assertions
   ack_after_take_a: assert property (tk |=> wb_ack_o)
      else $error("no ack after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   status_read_a: assert property (rd && wb_req_i.adr == 32'h4C && cv == 0 |=> wb_dat_o == {16'h0000, $past(st_q), $past(en_q)})
      else $error("status read value wrong");
   fc_read_a: assert property (rd && wb_req_i.adr == 32'h50 |=> wb_dat_o == 32'($past(fc_q)))
      else $error("false carrier count wrong");
   re_read_a: assert property (rd && wb_req_i.adr == 32'h54 |=> wb_dat_o == 32'($past(re_q)))
      else $error("receive error count wrong");
   irq_level_a: assert property ($past(hen_q) == 0 |-> irq_o == $past(|(st_q & en_q)))
      else $error("interrupt level wrong");
   fc_half_irq_a: assert property (rx_i.false_carrier && fc_q == 'h7F && !rd && !wr && hen_q[1] |-> ##[3:4] irq_o)
      else $error("no false carrier half-full interrupt");
   re_half_irq_a: assert property (re_hit && re_q == 'h7F && !rd && !wr && hen_q[0] |-> ##[3:4] irq_o)
      else $error("no receive error half-full interrupt");
   status_read_c: cover property (rd && wb_req_i.adr == 32'h4C && cv == 0);
   fc_full_c: cover property (fc_q == '1);
   re_full_c: cover property (re_q == '1);
   irq_c: cover property (irq_o);
endmodule
bind phy_event_status_and_error_counters phy_event_status_sva
#(
   .FC_WIDTH(FC_WIDTH),
   .RE_WIDTH(RE_WIDTH)
)
i_sva
(
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_req_i(wb_req_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .events_i(events_i),
   .rx_i(rx_i),
   .irq_o(irq_o)
);
`default_nettype wire

// ==== phy_event_status_and_error_counters_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module phy_event_status_and_error_counters_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   event_status_pkg::wb_req_type req = '0;
   event_status_pkg::phy_event_type ev = '0;
   event_status_pkg::rx_stat_type rx = '0;
   logic [31:0] dat, q;
   logic ack, irq;
   logic [4:0] r;
   logic [7:0] e;
   logic [7:0] exp_st [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h10,
      8'h08, 8'h04, 8'h02, 8'h02, 8'h01};
   int fails = 0;
   int samples_checked = 0;
   int ticks = 0;
   int n, fcn, ren;
   phy_event_status_and_error_counters i_dut
   (
      .clk_i(clk),
      .rst_i(rst),
      .wb_req_i(req),
      .wb_dat_o(dat),
      .wb_ack_o(ack),
      .events_i(ev),
      .rx_i(rx),
      .irq_o(irq)
   );
   always #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      ticks++;
      if (ticks == 80000)
      begin
         fails++;
         close_out;
      end
   end
   // =====
   // shared tasks
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want)
      begin
         fails++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, want);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d);
      req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      q = dat;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [31:0] a, want);
      bus(1'b0, a, 32'h0);
      check(q, want);
   endtask
   // =====
   // main sequence
   initial
   begin
      n = $urandom(67299);
      tick(10);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 32'h4C; a <= 32'h60; a += 4)
         rd(a, 32'h0);
      $display("reset test done");
      e = 8'($urandom);
      bus(1'b1, 32'h4C, {16'hFFFF, 8'hFF, e});
      rd(32'h4C, {24'h0, e});
      bus(1'b1, 32'h7C, 32'hFFFF_FFFF);
      rd(32'h7C, 32'h0);
      bus(1'b1, 32'h4C, 32'hFF);
      for (int j = 9; j >= 0; j--)
      begin
         ev <= ev ^ (10'h001 << j);
         @(posedge clk);
         if (j != 4 && j != 2)
            ev <= ev ^ (10'h001 << j);
         tick(2);
         check(irq, 32'h1);
         rd(32'h4C, {16'h0, exp_st[9-j], 8'hFF});
         rd(32'h4C, 32'hFF);
      end
      ev.jabber <= 1'b1;
      @(posedge clk);
      rd(32'h4C, 32'h1FF);
      rd(32'h4C, 32'h1FF);
      ev.jabber <= 1'b0;
      bus(1'b1, 32'h4C, 32'h0);
      $display("event test done");
      n = $urandom_range(126, 1);
      rx.false_carrier <= 1'b1;
      tick(n);
      rx.false_carrier <= 1'b0;
      rd(32'h50, n);
      rd(32'h50, 32'h0);
      bus(1'b1, 32'h60, 32'h3);
      rx.false_carrier <= 1'b1;
      tick(128);
      rx.false_carrier <= 1'b0;
      tick(4);
      check(irq, 32'h1);
      rd(32'h60, 32'h203);
      rx.false_carrier <= 1'b1;
      tick(300);
      rx.false_carrier <= 1'b0;
      rd(32'h50, 32'hFF);
      $display("false carrier test done");
      bus(1'b1, 32'h60, 32'h0);
      bus(1'b1, 32'h4C, 32'($urandom));
      fcn = 0;
      ren = 0;
      repeat (2000)
      begin
         r = 5'($urandom);
         rx <= r;
         ev <= 10'($urandom);
         if (r[4])
            fcn++;
         if (r[3:0] == 4'hE)
            ren++;
         @(posedge clk);
      end
      rx <= '0;
      ev <= '0;
      rd(32'h50, (fcn > 255) ? 32'hFF : fcn);
      rd(32'h54, ren);
      $display("random traffic test done");
      bus(1'b0, 32'h60, 32'h0);
      bus(1'b1, 32'h4C, 32'h0);
      bus(1'b1, 32'h60, 32'h1);
      rx <= 5'h0E;
      tick(65600);
      rx <= '0;
      tick(4);
      check(irq, 32'h1);
      rd(32'h54, 32'hFFFF);
      rd(32'h60, 32'h101);
      $display("receive error test done");
      close_out;
   end
endmodule
`default_nettype wire
